/* rtl/gpio_irq_pkg.sv */
/*
  Shared constants for the multiplexed pin block: register indices,
  field layouts, reset values and mode codes.
  Assumes a 32-bit APB master; each register is one aligned word at
  four times its index, with the 16-bit value in the low half.
*/
package gpio_irq_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [13:0] IDX_PORT_B_PIN_DATA    = 14'h0C04;
  localparam logic [13:0] IDX_PORT_B_PIN_MODE    = 14'h0C06;
  localparam logic [13:0] IDX_PORT_C_PIN_DATA    = 14'h0C08;
  localparam logic [13:0] IDX_PORT_C_PIN_MODE    = 14'h0C0A;
  localparam logic [13:0] IDX_PORT_D_PIN_DATA    = 14'h0C0C;
  localparam logic [13:0] IDX_PORT_D_PIN_MODE    = 14'h0C0E;
  localparam logic [13:0] IDX_PORT_G_PIN_DATA    = 14'h0C18;
  localparam logic [13:0] IDX_PORT_G_PIN_MODE    = 14'h0C1A;
  localparam logic [13:0] IDX_PIN_IRQ_TRIG_KIND  = 14'h0C24;
  localparam logic [13:0] IDX_PIN_IRQ_POLARITY   = 14'h0C26;
  localparam logic [13:0] IDX_PIN_IRQ_ENABLE     = 14'h0C28;
  localparam logic [13:0] IDX_PIN_IRQ_PENDING    = 14'h0C2A;

  // ----------------------------------------------------------------
  // Implemented bit masks of each 16-bit register
  // ----------------------------------------------------------------
  localparam logic [15:0] MASK_PORT_B_DATA = 16'h00F0;
  localparam logic [15:0] MASK_PORT_B_MODE = 16'hFF00;
  localparam logic [15:0] MASK_PORT_C_DATA = 16'h00FF;
  localparam logic [15:0] MASK_PORT_C_MODE = 16'hFFFF;
  localparam logic [15:0] MASK_PORT_D_DATA = 16'h000F;
  localparam logic [15:0] MASK_PORT_D_MODE = 16'h00FF;
  localparam logic [15:0] MASK_PORT_G_DATA = 16'h001F;
  localparam logic [15:0] MASK_PORT_G_MODE = 16'h03FF;
  localparam logic [15:0] MASK_PIN_IRQ     = 16'hF0F0;

  // Field positions: port B pins 7:4 sit at bits 7:4 of data, 15:8 of mode
  localparam int POS_PORT_B_DATA = 4;
  localparam int POS_PORT_B_MODE = 8;
  // Interrupt fields: port A at bits 7:4, port B at bits 15:12
  localparam int POS_IRQ_PORT_A  = 4;
  localparam int POS_IRQ_PORT_B  = 12;

  // Every register resets to zero: all pins inputs, interrupts off
  localparam logic [15:0] REG_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Two-bit pin mode codes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_INPUT  = 2'h0;
  localparam logic [1:0] MODE_ALT1   = 2'h1;
  localparam logic [1:0] MODE_OUTPUT = 2'h2;
  localparam logic [1:0] MODE_ALT2   = 2'h3;

endpackage

/* rtl/gpio_irq_ports.sv */
/*
  Multiplexed pin block: ports B (pins 7:4), C, D and G with mode and
  data registers, plus level or edge interrupts on ports A and B pins 7:4.
  Assumes pin inputs are already synchronous to i_clk and that an
  outside pad mux uses the oe and alternate-function selects.
*/
// Added by the designer: the APB register port.
`timescale 1ns/10ps

// Behaviour
// [RL1] Port B mode: 00 input, 01 alternate one, 10 output, 11 reserved.
// [RL2] Software avoids alternate one on port B pins 6 to 4.
// [RL3] Port C mode: only input and output; codes 01 and 11 reserved.
// [RL4] Port D mode encodes like port B; alternate one avoided on pins 2-0.
// [RL5] Port G mode: 00 input, 10 output, 11 alternate two, 01 reserved.
// [RL6] Reading an input pin's data bit returns the sampled pin level.
// [RL7] Reading an output pin's data bit returns the stored register bit.
// [RL8] A stored data one drives an output pin high.
// [RL9] Data bits: port C 7-0, port D 3-0, port G 4-0, rest unused.
// [RL10] Mode fields two bits per pin at 2n+1:2n in the stated ranges.
// [RL11] All data, mode and interrupt registers reset to zero.
// [RL12] Interrupt type bit: zero level, one edge; B 15-12, A 7-4.
// [RL13] Polarity zero means high or rising, one means low or falling.
// [RL14] Only an enabled pin's condition may raise its interrupt.
// [RL15] Status bit reads one once an enabled condition has occurred.
// [RL16] Software clears pending status before changing type or polarity.
// [RL17] Software sets type and polarity before enabling an interrupt.
// [RL18] Software does not write the reserved addresses between registers.
// [RL19] Writing zero clears status, one leaves it; an active level resets it.
// [RL20] Interrupt request is the OR of enabled status bits.
module gpio_irq_ports
  import gpio_irq_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire logic [3:0]        i_port_a_in,
  input  wire logic [3:0]        i_port_b_in,
  output logic      [3:0]        o_port_b_out,
  output logic      [3:0]        o_port_b_oe,
  output logic      [3:0]        o_port_b_alt1,
  input  wire logic [7:0]        i_port_c_in,
  output logic      [7:0]        o_port_c_out,
  output logic      [7:0]        o_port_c_oe,
  input  wire logic [3:0]        i_port_d_in,
  output logic      [3:0]        o_port_d_out,
  output logic      [3:0]        o_port_d_oe,
  output logic      [3:0]        o_port_d_alt1,
  input  wire logic [4:0]        i_port_g_in,
  output logic      [4:0]        o_port_g_out,
  output logic      [4:0]        o_port_g_oe,
  output logic      [4:0]        o_port_g_alt2,
  output logic                   o_irq
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // One bit per pin: field at 2n+1:2n equals the given code
  function automatic logic [7:0] mode_is(input logic [15:0] mode, input logic [1:0] code);
    logic [7:0] hit;
    hit = 8'h00;
    for (int n = 0; n < 8; n++) begin
      hit[n] = (mode[2*n +: 2] == code);
    end
    return hit;
  endfunction

  // Word-aligned match of the APB address against a register index
  function automatic logic addr_is(input logic [ADDR_W-1:0] addr, input logic [13:0] idx);
    return (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx)) && (addr[1:0] == 2'h0);
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] port_b_data_r;
  logic [15:0] port_b_mode_r;
  logic [15:0] port_c_data_r;
  logic [15:0] port_c_mode_r;
  logic [15:0] port_d_data_r;
  logic [15:0] port_d_mode_r;
  logic [15:0] port_g_data_r;
  logic [15:0] port_g_mode_r;
  logic [15:0] irq_kind_r;
  logic [15:0] irq_pol_r;
  logic [15:0] irq_en_r;
  logic [15:0] irq_pend_r;
  logic [15:0] irq_pend_nxt;
  logic [15:0] pin_prev_r;

  // ----------------------------------------------------------------
  // APB access decode
  // ----------------------------------------------------------------
  logic        acc_ph;
  logic        wr_take;
  logic        sel_b_data;
  logic        sel_b_mode;
  logic        sel_c_data;
  logic        sel_c_mode;
  logic        sel_d_data;
  logic        sel_d_mode;
  logic        sel_g_data;
  logic        sel_g_mode;
  logic        sel_kind;
  logic        sel_pol;
  logic        sel_en;
  logic        sel_pend;
  logic        sel_any;
  logic [15:0] wdata;

  // Access phase first cycle; the answer follows one cycle later
  assign acc_ph     = i_psel && i_penable && !o_pready;
  // Write lands only on the edge where pready is seen high
  assign wr_take    = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;
  assign wdata      = i_pwdata[15:0];
  assign sel_b_data = addr_is(i_paddr, IDX_PORT_B_PIN_DATA);
  assign sel_b_mode = addr_is(i_paddr, IDX_PORT_B_PIN_MODE);
  assign sel_c_data = addr_is(i_paddr, IDX_PORT_C_PIN_DATA);
  assign sel_c_mode = addr_is(i_paddr, IDX_PORT_C_PIN_MODE);
  assign sel_d_data = addr_is(i_paddr, IDX_PORT_D_PIN_DATA);
  assign sel_d_mode = addr_is(i_paddr, IDX_PORT_D_PIN_MODE);
  assign sel_g_data = addr_is(i_paddr, IDX_PORT_G_PIN_DATA);
  assign sel_g_mode = addr_is(i_paddr, IDX_PORT_G_PIN_MODE);
  assign sel_kind   = addr_is(i_paddr, IDX_PIN_IRQ_TRIG_KIND);
  assign sel_pol    = addr_is(i_paddr, IDX_PIN_IRQ_POLARITY);
  assign sel_en     = addr_is(i_paddr, IDX_PIN_IRQ_ENABLE);
  assign sel_pend   = addr_is(i_paddr, IDX_PIN_IRQ_PENDING);
  // [RL18] reserved gaps error
  assign sel_any    = sel_b_data | sel_b_mode | sel_c_data | sel_c_mode | sel_d_data | sel_d_mode
                    | sel_g_data | sel_g_mode | sel_kind | sel_pol | sel_en | sel_pend;

  // ----------------------------------------------------------------
  // Pin direction decode (current register contents)
  // ----------------------------------------------------------------
  logic [7:0] c_is_out;
  logic [7:0] b_is_out;
  logic [7:0] b_is_alt1;
  logic [7:0] d_is_out;
  logic [7:0] d_is_alt1;
  logic [7:0] g_is_out;
  logic [7:0] g_is_alt2;

  // [RL10] two bits per pin
  assign b_is_out  = mode_is(port_b_mode_r >> POS_PORT_B_MODE, MODE_OUTPUT);
  // [RL1] port B alternate one
  assign b_is_alt1 = mode_is(port_b_mode_r >> POS_PORT_B_MODE, MODE_ALT1);
  // [RL3] C only output code drives; 01 and 11 fall back to input
  assign c_is_out  = mode_is(port_c_mode_r, MODE_OUTPUT);
  // [RL4] port D as port B
  assign d_is_out  = mode_is(port_d_mode_r, MODE_OUTPUT);
  assign d_is_alt1 = mode_is(port_d_mode_r, MODE_ALT1);
  // [RL5] G alternate two on 11
  assign g_is_out  = mode_is(port_g_mode_r, MODE_OUTPUT);
  assign g_is_alt2 = mode_is(port_g_mode_r, MODE_ALT2);

  // ----------------------------------------------------------------
  // Data read-back: pin level for inputs, latch for outputs
  // ----------------------------------------------------------------
  logic [15:0] rd_b_data;
  logic [15:0] rd_c_data;
  logic [15:0] rd_d_data;
  logic [15:0] rd_g_data;

  // [RL6] input returns pin
  // [RL7] output returns latch
  assign rd_b_data = {8'h00, (port_b_data_r[7:4] & b_is_out[3:0]) | (i_port_b_in & ~b_is_out[3:0]), 4'h0};
  assign rd_c_data = {8'h00, (port_c_data_r[7:0] & c_is_out) | (i_port_c_in & ~c_is_out)};
  assign rd_d_data = {12'h000, (port_d_data_r[3:0] & d_is_out[3:0]) | (i_port_d_in & ~d_is_out[3:0])};
  assign rd_g_data = {11'h000, (port_g_data_r[4:0] & g_is_out[4:0]) | (i_port_g_in & ~g_is_out[4:0])};

  // ----------------------------------------------------------------
  // APB answer: one wait state so read data comes from a flop
  // ----------------------------------------------------------------
  logic [15:0] rd_mux;

  always_comb begin
    rd_mux = 16'h0000;
    case (1'b1)
      sel_b_data: rd_mux = rd_b_data;
      sel_b_mode: rd_mux = port_b_mode_r;
      sel_c_data: rd_mux = rd_c_data;
      sel_c_mode: rd_mux = port_c_mode_r;
      sel_d_data: rd_mux = rd_d_data;
      sel_d_mode: rd_mux = port_d_mode_r;
      sel_g_data: rd_mux = rd_g_data;
      sel_g_mode: rd_mux = port_g_mode_r;
      sel_kind:   rd_mux = irq_kind_r;
      sel_pol:    rd_mux = irq_pol_r;
      sel_en:     rd_mux = irq_en_r;
      sel_pend:   rd_mux = irq_pend_r;
      default:    rd_mux = 16'h0000;
    endcase
  end

  // Ready pulses for one cycle; unmapped address answers with slverr
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= acc_ph;
      o_pslverr <= acc_ph && !sel_any;
      if (acc_ph && !i_pwrite) begin
        o_prdata <= {16'h0000, rd_mux};
      end
    end
  end

  // ----------------------------------------------------------------
  // Port data and mode registers
  // ----------------------------------------------------------------

  // [RL11] zero reset
  // [RL9] unused bits stay zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      port_b_data_r <= REG_RESET;
      port_b_mode_r <= REG_RESET;
      port_c_data_r <= REG_RESET;
      port_c_mode_r <= REG_RESET;
      port_d_data_r <= REG_RESET;
      port_d_mode_r <= REG_RESET;
      port_g_data_r <= REG_RESET;
      port_g_mode_r <= REG_RESET;
    end else if (wr_take) begin
      if (sel_b_data) port_b_data_r <= wdata & MASK_PORT_B_DATA;
      if (sel_b_mode) port_b_mode_r <= wdata & MASK_PORT_B_MODE;
      if (sel_c_data) port_c_data_r <= wdata & MASK_PORT_C_DATA;
      if (sel_c_mode) port_c_mode_r <= wdata & MASK_PORT_C_MODE;
      if (sel_d_data) port_d_data_r <= wdata & MASK_PORT_D_DATA;
      if (sel_d_mode) port_d_mode_r <= wdata & MASK_PORT_D_MODE;
      if (sel_g_data) port_g_data_r <= wdata & MASK_PORT_G_DATA;
      if (sel_g_mode) port_g_mode_r <= wdata & MASK_PORT_G_MODE;
    end
  end

  // ----------------------------------------------------------------
  // Pad-side outputs, registered one cycle after the mode/data change
  // ----------------------------------------------------------------

  // [RL8] latch drives pin level
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_port_b_out  <= 4'h0;
      o_port_b_oe   <= 4'h0;
      o_port_b_alt1 <= 4'h0;
      o_port_c_out  <= 8'h00;
      o_port_c_oe   <= 8'h00;
      o_port_d_out  <= 4'h0;
      o_port_d_oe   <= 4'h0;
      o_port_d_alt1 <= 4'h0;
      o_port_g_out  <= 5'h00;
      o_port_g_oe   <= 5'h00;
      o_port_g_alt2 <= 5'h00;
    end else begin
      o_port_b_out  <= port_b_data_r[POS_PORT_B_DATA +: 4];
      o_port_b_oe   <= b_is_out[3:0];
      o_port_b_alt1 <= b_is_alt1[3:0];
      o_port_c_out  <= port_c_data_r[7:0];
      o_port_c_oe   <= c_is_out;
      o_port_d_out  <= port_d_data_r[3:0];
      o_port_d_oe   <= d_is_out[3:0];
      o_port_d_alt1 <= d_is_alt1[3:0];
      o_port_g_out  <= port_g_data_r[4:0];
      o_port_g_oe   <= g_is_out[4:0];
      o_port_g_alt2 <= g_is_alt2[4:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt configuration
  // ----------------------------------------------------------------

  // [RL12] type, polarity, enable
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_kind_r <= REG_RESET;
      irq_pol_r  <= REG_RESET;
      irq_en_r   <= REG_RESET;
    end else if (wr_take) begin
      if (sel_kind) irq_kind_r <= wdata & MASK_PIN_IRQ;
      if (sel_pol)  irq_pol_r  <= wdata & MASK_PIN_IRQ;
      if (sel_en)   irq_en_r   <= wdata & MASK_PIN_IRQ;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt detection
  // ----------------------------------------------------------------
  logic [15:0] pin_now;
  logic [15:0] irq_cond;
  logic [15:0] irq_set;
  logic [15:0] irq_clr;

  assign pin_now = {i_port_b_in, 4'h0, i_port_a_in, 4'h0};

  // Previous pin levels for edge detection
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pin_prev_r <= 16'h0000;
    end else begin
      pin_prev_r <= pin_now;
    end
  end

  // Per-pin condition; edge uses the previous sample, which resets to zero,
  // so a pin already high at reset release shows a rising edge in the first cycle
  generate
    for (genvar k = 0; k < 16; k++) begin : g_cond
      // [RL13] polarity inverts sense
      assign irq_cond[k] = irq_kind_r[k]
                         ? ((pin_now[k] ^ irq_pol_r[k]) && !(pin_prev_r[k] ^ irq_pol_r[k]))
                         : (pin_now[k] ^ irq_pol_r[k]);
    end
  endgenerate

  // [RL14] enable gates set
  assign irq_set = irq_cond & irq_en_r & MASK_PIN_IRQ;
  // [RL19] zero written clears
  assign irq_clr = (wr_take && sel_pend) ? (~wdata & MASK_PIN_IRQ) : 16'h0000;
  // Set wins over a clear in the same cycle, so no event is lost
  assign irq_pend_nxt = (irq_pend_r & ~irq_clr) | irq_set;

  // [RL15] sticky status
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_pend_r <= REG_RESET;
    end else begin
      irq_pend_r <= irq_pend_nxt;
    end
  end

  // [RL20] OR of enabled status
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_pend_r & irq_en_r);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_access;
    i_psel && i_penable && !o_pready;
  endsequence

  sequence s_answer;
    o_pready ##1 !o_pready;
  endsequence

  property p_apb_answer;
    s_access |=> s_answer;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb ready not one cycle after access");

  property p_b_mode_decode;
    (port_b_mode_r[15:14] == 2'h1) |=> (o_port_b_alt1[3] && !o_port_b_oe[3]);
  endproperty
  a_b_mode_decode: assert property (p_b_mode_decode) else $error("port b alt1 decode wrong"); // [RL1]

  property p_c_reserved;
    (port_c_mode_r[1:0] != 2'h2) |=> !o_port_c_oe[0];
  endproperty
  a_c_reserved: assert property (p_c_reserved) else $error("port c drives on non-output code"); // [RL3]

  property p_d_alt1;
    (port_d_mode_r[7:6] == 2'h1) |=> o_port_d_alt1[3];
  endproperty
  a_d_alt1: assert property (p_d_alt1) else $error("port d alt1 missing"); // [RL4]

  property p_g_alt2;
    (port_g_mode_r[9:8] == 2'h3) |=> (o_port_g_alt2[4] && !o_port_g_oe[4]);
  endproperty
  a_g_alt2: assert property (p_g_alt2) else $error("port g alt2 decode wrong"); // [RL5]

  property p_c_read_input;
    (s_access and (sel_c_data && !i_pwrite && port_c_mode_r == 16'h0000))
      |=> (o_prdata[7:0] == $past(i_port_c_in));
  endproperty
  a_c_read_input: assert property (p_c_read_input) else $error("input read not pin level"); // [RL6]

  property p_c_read_output;
    (s_access and (sel_c_data && !i_pwrite && port_c_mode_r[1:0] == MODE_OUTPUT))
      |=> (o_prdata[0] == $past(port_c_data_r[0]));
  endproperty
  a_c_read_output: assert property (p_c_read_output) else $error("output read not latch"); // [RL7]

  property p_c_drive;
    (port_c_mode_r[1:0] == MODE_OUTPUT) |=> (o_port_c_oe[0] && o_port_c_out[0] == $past(port_c_data_r[0]));
  endproperty
  a_c_drive: assert property (p_c_drive) else $error("output pin level wrong"); // [RL8]

  property p_rise_edge;
    (irq_kind_r[5] && !irq_pol_r[5] && irq_en_r[5] && !pin_prev_r[5] && pin_now[5]) |=> irq_pend_r[5];
  endproperty
  a_rise_edge: assert property (p_rise_edge) else $error("rising edge not latched"); // [RL13]

  property p_enable_gate;
    $rose(irq_pend_r[12]) |-> $past(irq_en_r[12]);
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("status set while disabled"); // [RL14]

  property p_clear;
    (wr_take && sel_pend && !wdata[15] && !irq_set[15]) |=> !irq_pend_r[15];
  endproperty
  a_clear: assert property (p_clear) else $error("status not cleared by zero write"); // [RL19]

  property p_sticky;
    (irq_pend_r[7] && !(wr_take && sel_pend && !wdata[7])) |=> irq_pend_r[7];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status lost without clear"); // [RL15]

  property p_irq_out;
    (|(irq_pend_r & irq_en_r)) |=> o_irq;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("irq not raised"); // [RL20]

  property p_irq_quiet;
    !(|(irq_pend_r & irq_en_r)) |=> !o_irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq raised with no enabled status"); // [RL20]

endmodule

/* sim/board_pins.sv */
/*
  Board model for one port of multiplexed pads.
  Assumes the bench sets the outside level; a pad the block drives wins.
*/
`timescale 1ns/10ps

module board_pins #(
  parameter int W = 4
) (
  input  wire logic [W-1:0] i_ext,
  input  wire logic [W-1:0] i_out,
  input  wire logic [W-1:0] i_oe,
  output logic      [W-1:0] o_pin
);
  // ----------------------------------------------------------------
  // Pad resolution
  // ----------------------------------------------------------------
  // Driven pads show the block's level, idle ones the board's
  always_comb begin
    for (int k = 0; k < W; k++) begin
      o_pin[k] = i_oe[k] ? i_out[k] : i_ext[k];
    end
  end
endmodule

/* sim/testbench.sv */
/*
  Self-checking bench for the pin block: APB registers, pads, interrupts.
  Assumes one board model per port closes the pads; port A is fed directly.
*/
`timescale 1ns/10ps

module testbench
  import gpio_irq_pkg::*;
;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [15:0] paddr, r;
  logic [31:0] pwdata, prdata;
  logic [3:0]  ext_a, ext_b, ext_d, pin_b, pin_d, b_out, b_oe, b_alt1, d_out, d_oe, d_alt1;
  logic [7:0]  ext_c, pin_c, c_out, c_oe;
  logic [4:0]  ext_g, pin_g, g_out, g_oe, g_alt2;
  int          miscompares = 0;
  int          check_count = 0;
  localparam logic [13:0] ALL_REGS [12] = '{IDX_PORT_B_PIN_DATA, IDX_PORT_B_PIN_MODE, IDX_PORT_C_PIN_DATA,
    IDX_PORT_C_PIN_MODE, IDX_PORT_D_PIN_DATA, IDX_PORT_D_PIN_MODE, IDX_PORT_G_PIN_DATA, IDX_PORT_G_PIN_MODE,
    IDX_PIN_IRQ_TRIG_KIND, IDX_PIN_IRQ_POLARITY, IDX_PIN_IRQ_ENABLE, IDX_PIN_IRQ_PENDING};

  // ----------------------------------------------------------------
  // Block and board
  // ----------------------------------------------------------------
  gpio_irq_ports dut (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_port_a_in(ext_a), .i_port_b_in(pin_b), .o_port_b_out(b_out), .o_port_b_oe(b_oe), .o_port_b_alt1(b_alt1),
    .i_port_c_in(pin_c), .o_port_c_out(c_out), .o_port_c_oe(c_oe), .i_port_d_in(pin_d), .o_port_d_out(d_out),
    .o_port_d_oe(d_oe), .o_port_d_alt1(d_alt1), .i_port_g_in(pin_g), .o_port_g_out(g_out), .o_port_g_oe(g_oe),
    .o_port_g_alt2(g_alt2), .o_irq(irq));
  board_pins #(.W(4)) pads_b (.i_ext(ext_b), .i_out(b_out), .i_oe(b_oe), .o_pin(pin_b));
  board_pins #(.W(8)) pads_c (.i_ext(ext_c), .i_out(c_out), .i_oe(c_oe), .o_pin(pin_c));
  board_pins #(.W(4)) pads_d (.i_ext(ext_d), .i_out(d_out), .i_oe(d_oe), .o_pin(pin_d));
  board_pins #(.W(5)) pads_g (.i_ext(ext_g), .i_out(g_out), .i_oe(g_oe), .o_pin(pin_g));

  // 50 MHz clock
  always #10 clk = ~clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Request held until pready is seen; an idle edge follows the release
  task automatic apb(input logic wr, input logic [15:0] a, input logic [15:0] wd,
                     output logic [15:0] rd, output logic err);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {16'hFFFF, wd};
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) miscompares++;
    rd = prdata[15:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [13:0] idx, input logic [15:0] d);
    apb(1'b1, {idx, 2'b00}, d, r, e);
  endtask

  task automatic rd_chk(input logic [13:0] idx, input logic [15:0] exp);
    apb(1'b0, {idx, 2'b00}, 16'h0000, r, e);
    chk(r, exp);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // All pads are held low here, so input pins read back as zero
  task automatic t_reset();
    foreach (ALL_REGS[i]) rd_chk(ALL_REGS[i], REG_RESET);
    chk({c_oe, c_out}, 16'h0000);
  endtask

  // Reserved, unmapped and misaligned places answer with an error
  task automatic t_refuse();
    apb(1'b0, 16'h3040, 16'h0000, r, e);
    chk({e, r[14:0]}, 16'h8000);
    apb(1'b1, 16'h3000, 16'hFFFF, r, e);
    chk({e, 15'h0000}, 16'h8000);
    apb(1'b1, {IDX_PORT_C_PIN_MODE, 2'b10}, 16'hFFFF, r, e);
    chk({e, 15'h0000}, 16'h8000);
    rd_chk(IDX_PORT_C_PIN_MODE, 16'h0000);
  endtask

  // Type and polarity set while nothing is pending, before enabling
  task automatic t_irq();
    wr(IDX_PIN_IRQ_TRIG_KIND, 16'h00F0);
    wr(IDX_PIN_IRQ_POLARITY, 16'h3050);
    // Port B pins 5:4 high keeps their low-level sources quiet
    ext_b <= 4'h3;
    ext_a <= 4'hF;
    tick(3);
    rd_chk(IDX_PIN_IRQ_PENDING, 16'h0000);
    ext_a <= 4'h0;
    tick(2);
    wr(IDX_PIN_IRQ_ENABLE, 16'hF0F0);
    ext_a <= 4'hF;
    tick(3);
    rd_chk(IDX_PIN_IRQ_PENDING, 16'h00A0);
    ext_a <= 4'h0;
    tick(3);
    rd_chk(IDX_PIN_IRQ_PENDING, 16'h00F0);
    chk({15'h0000, irq}, 16'h0001);
    wr(IDX_PIN_IRQ_PENDING, 16'hFF5F);
    rd_chk(IDX_PIN_IRQ_PENDING, 16'h0050);
    ext_b <= 4'hF;
    tick(3);
    rd_chk(IDX_PIN_IRQ_PENDING, 16'hC050);
    wr(IDX_PIN_IRQ_PENDING, 16'h0000);
    rd_chk(IDX_PIN_IRQ_PENDING, 16'hC000);
    ext_b <= 4'h0;
    tick(3);
    wr(IDX_PIN_IRQ_PENDING, 16'h0000);
    rd_chk(IDX_PIN_IRQ_PENDING, 16'h3000);
    wr(IDX_PIN_IRQ_ENABLE, 16'h0000);
    wr(IDX_PIN_IRQ_PENDING, 16'h0000);
    rd_chk(IDX_PIN_IRQ_PENDING, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
  endtask

  // Upper pins take reserved codes and must stay inputs
  task automatic t_port_c();
    ext_c <= 8'hF0;
    wr(IDX_PORT_C_PIN_MODE, 16'h7DAA);
    wr(IDX_PORT_C_PIN_DATA, 16'hFF55);
    tick(2);
    rd_chk(IDX_PORT_C_PIN_MODE, 16'h7DAA);
    rd_chk(IDX_PORT_C_PIN_DATA, 16'h00F5);
    chk({c_oe, c_out}, 16'h0F55);
  endtask

  // Alternate one only on port B pin 7 and port D pin 3
  task automatic t_modes();
    wr(IDX_PORT_B_PIN_MODE, 16'h6CFF);
    wr(IDX_PORT_D_PIN_MODE, 16'hFF6C);
    wr(IDX_PORT_G_PIN_MODE, 16'hFF92);
    wr(IDX_PORT_B_PIN_DATA, 16'h00F0);
    wr(IDX_PORT_D_PIN_DATA, 16'h000F);
    wr(IDX_PORT_G_PIN_DATA, 16'h001F);
    ext_d <= 4'h1;
    tick(2);
    rd_chk(IDX_PORT_B_PIN_MODE, 16'h6C00);
    rd_chk(IDX_PORT_D_PIN_MODE, 16'h006C);
    rd_chk(IDX_PORT_G_PIN_MODE, 16'h0392);
    rd_chk(IDX_PORT_B_PIN_DATA, 16'h0040);
    rd_chk(IDX_PORT_D_PIN_DATA, 16'h0005);
    rd_chk(IDX_PORT_G_PIN_DATA, 16'h0009);
    chk({8'h00, b_alt1, b_oe}, 16'h0084);
    chk({8'h00, d_alt1, d_oe}, 16'h0084);
    chk({6'h00, g_alt2, g_oe}, 16'h0209);
    chk({3'h0, b_out, d_out, g_out}, 16'h1FFF);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk     = 1'b0;
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 16'h0000;
    pwdata  = 32'h0000_0000;
    ext_a   = 4'h0;
    ext_b   = 4'h0;
    ext_c   = 8'h00;
    ext_d   = 4'h0;
    ext_g   = 5'h00;
    tick(4);
    rst_n <= 1'b1;
    tick(1);
    t_reset();
    t_refuse();
    t_irq();
    t_port_c();
    t_modes();
    // Second reset in mid-run must clear everything again
    ext_c <= 8'h00;
    ext_d <= 4'h0;
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    tick(1);
    t_reset();
    wrap_up();
  end

  // Whole run is a few hundred cycles; this span is far beyond it
  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end
endmodule
